// File: ufm_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ufm_flow_ctrl #(
    parameter int BITW = 16,
    parameter int CNTW = 10
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    // Configuration
    input  wire logic [7:0]      flow_cfg_wr,
    input  wire logic            flow_cfg_we,
    output logic      [7:0]      flow_cfg_rd,
    input  wire logic [2:0]      pin_func,
    input  wire logic [3:0]      turnaround_delay_reg,
    input  wire logic [7:0]      resume_char,
    input  wire logic [7:0]      pause_char,
    input  wire logic [BITW-1:0] bit_cycles,
    input  wire logic            low_latency_bit,
    input  wire logic            line_coding_stb,
    input  wire logic [23:0]     line_coding_baud,
    // General-purpose pins
    input  wire logic [5:0]      gpio_in,
    input  wire logic [5:0]      gpio_dout,
    input  wire logic [5:0]      gpio_dir,
    output logic      [5:0]      gpio_out,
    output logic      [5:0]      gpio_oe,
    // Transmitter
    input  wire logic            tx_busy,
    input  wire logic            tx_done,
    input  wire logic            tx_empty,
    output logic                 tx_allow,
    // Receiver
    input  wire logic            rx_line_in,
    output logic                 rx_line_out,
    input  wire logic            rx_valid,
    input  wire logic [7:0]      rx_data,
    input  wire logic            rx_bit9,
    output logic                 rx_store,
    output logic      [7:0]      rx_store_data,
    output logic                 rx_enabled,
    input  wire logic            rx_fifo_room,
    input  wire logic [CNTW-1:0] rx_fifo_count,
    // Bulk-in
    input  wire logic            bulkin_req,
    output logic                 bulkin_grant,
    output logic      [6:0]      bulkin_len,
    output logic                 low_latency,
    // Suspend and wakeup
    input  wire logic            suspended,
    input  wire logic            wake_attr,
    output logic                 remote_wake
);
    logic [3:0]      cfg_ff;
    logic [5:0]      pin_out_ff;
    logic [5:0]      pin_oe_ff;
    logic            tx_allow_ff;
    logic            rx_line_ff;
    logic            rx_store_ff;
    logic [7:0]      rx_data_ff;
    logic            match_ff;
    logic            paused_ff;
    logic            bulkin_grant_ff;
    logic [6:0]      bulkin_len_ff;
    logic            auto_ll_ff;
    logic            low_latency_ff;
    logic            ring_prev_ff;
    logic            wake_ff;
    logic            rx_en_ff;
    logic            rx_take;
    logic            xcvr_hold;
    logic [2:0]      mode;
    logic            half_duplex;
    logic            hw_rts;
    logic            hw_dtr;
    logic            multidrop;
    logic            addr_hit;
    logic            throttle_in;
    logic            nxt_tx_allow;

    assign mode        = cfg_ff[2:0];
    assign half_duplex = cfg_ff[ufm_pkg::HALF_DUPLEX_BIT];
    assign hw_rts      = (mode == ufm_pkg::MODE_HW) && (pin_func == ufm_pkg::PINF_RTS);
    assign hw_dtr      = (mode == ufm_pkg::MODE_HW) && (pin_func == ufm_pkg::PINF_DTR);
    assign multidrop   = (mode == ufm_pkg::MODE_MD3) || (mode == ufm_pkg::MODE_MD4);
    assign addr_hit    = (rx_data == resume_char) || (rx_data == pause_char);
    assign rx_take     = rx_valid && !(half_duplex && tx_busy);

    // Handshake configuration byte, upper nibble reads zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            cfg_ff <= ufm_pkg::FLOW_CFG_RESET[3:0];
        else if (flow_cfg_we)
            cfg_ff <= flow_cfg_wr[3:0];
    end
    assign flow_cfg_rd = {4'h0, cfg_ff};

    // Direction line hold through the frame and the turnaround delay
    ufm_turnaround #(
        .BITW (BITW)
    ) u_turnaround (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .tx_busy    (tx_busy),
        .tx_done    (tx_done),
        .tx_empty   (tx_empty),
        .delay_bits (turnaround_delay_reg),
        .bit_cycles (bit_cycles),
        .hold       (xcvr_hold)
    );

    // Pin drivers: GPIO by default, modem or transceiver lines by function
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pin_out_ff <= 6'h00;
            pin_oe_ff  <= 6'h00;
        end else begin
            pin_out_ff <= gpio_dout;
            pin_oe_ff  <= gpio_dir;
            if (hw_rts) begin
                pin_out_ff[ufm_pkg::PIN_RTS] <= ~rx_fifo_room;
                pin_oe_ff[ufm_pkg::PIN_RTS]  <= 1'b1;
                pin_oe_ff[ufm_pkg::PIN_CTS]  <= 1'b0;
            end else if (hw_dtr) begin
                pin_out_ff[ufm_pkg::PIN_DTR] <= ~rx_fifo_room;
                pin_oe_ff[ufm_pkg::PIN_DTR]  <= 1'b1;
                pin_oe_ff[ufm_pkg::PIN_DSR]  <= 1'b0;
            end else if (pin_func == ufm_pkg::PINF_XCVR) begin
                pin_out_ff[ufm_pkg::PIN_RTS] <= ~xcvr_hold;
                pin_oe_ff[ufm_pkg::PIN_RTS]  <= 1'b1;
            end
        end
    end
    assign gpio_out = pin_out_ff;
    assign gpio_oe  = pin_oe_ff;

    // Remote throttle input, active low
    always_comb begin
        throttle_in = 1'b0;
        if (hw_rts)
            throttle_in = gpio_in[ufm_pkg::PIN_CTS];
        else if (hw_dtr)
            throttle_in = gpio_in[ufm_pkg::PIN_DSR];
    end

    // Transmit permission; gating only the next start lets a character finish
    always_comb begin
        case (mode)
            ufm_pkg::MODE_NONE: nxt_tx_allow = 1'b1;
            ufm_pkg::MODE_HW:   nxt_tx_allow = ~throttle_in;
            ufm_pkg::MODE_SW:   nxt_tx_allow = ~paused_ff;
            ufm_pkg::MODE_MD3:  nxt_tx_allow = 1'b1;
            ufm_pkg::MODE_MD4:  nxt_tx_allow = match_ff;
            default:            nxt_tx_allow = 1'b1;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            tx_allow_ff <= 1'b1;
        else
            tx_allow_ff <= nxt_tx_allow;
    end
    assign tx_allow = tx_allow_ff;

    // Pause and resume characters
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            paused_ff <= 1'b0;
        else if (mode != ufm_pkg::MODE_SW)
            paused_ff <= 1'b0;
        else if (rx_take && rx_data == pause_char)
            paused_ff <= 1'b1;
        else if (rx_take && rx_data == resume_char)
            paused_ff <= 1'b0;
    end

    // Half-duplex: receive line held idle while transmitting
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            rx_line_ff <= 1'b1;
        else
            rx_line_ff <= (half_duplex && tx_busy) ? 1'b1 : rx_line_in;
    end
    assign rx_line_out = rx_line_ff;

    // Address match state for multidrop; registered receiver enable follows it
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            match_ff <= 1'b0;
            rx_en_ff <= 1'b1;
        end else if (!multidrop) begin
            match_ff <= 1'b0;
            rx_en_ff <= 1'b1;
        end else if (rx_take && rx_bit9) begin
            match_ff <= addr_hit;
            rx_en_ff <= addr_hit;
        end else begin
            rx_en_ff <= match_ff;
        end
    end
    assign rx_enabled = rx_en_ff;

    // Receive store path: address bytes never reach the FIFO in multidrop modes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_store_ff <= 1'b0;
            rx_data_ff  <= 8'h00;
        end else begin
            rx_store_ff <= 1'b0;
            if (rx_take) begin
                if (!multidrop) begin
                    rx_store_ff <= 1'b1;
                    rx_data_ff  <= rx_data;
                end else if (!rx_bit9 && match_ff) begin
                    rx_store_ff <= 1'b1;
                    rx_data_ff  <= rx_data;
                end
            end
        end
    end
    assign rx_store      = rx_store_ff;
    assign rx_store_data = rx_data_ff;

    // Low-latency mode from line coding or the control bit
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            auto_ll_ff     <= 1'b0;
            low_latency_ff <= 1'b0;
        end else begin
            if (line_coding_stb)
                auto_ll_ff <= (line_coding_baud < ufm_pkg::LOWLAT_BAUD);
            low_latency_ff <= auto_ll_ff | low_latency_bit;
        end
    end
    assign low_latency = low_latency_ff;

    // Bulk-in grant: full packets normally, any data in low latency
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bulkin_grant_ff <= 1'b0;
            bulkin_len_ff   <= 7'h00;
        end else begin
            bulkin_grant_ff <= 1'b0;
            if (bulkin_req) begin
                if (rx_fifo_count >= CNTW'(ufm_pkg::PKT_MAX)) begin
                    bulkin_grant_ff <= 1'b1;
                    bulkin_len_ff   <= ufm_pkg::PKT_MAX[6:0];
                end else if (low_latency_ff && rx_fifo_count != '0) begin
                    bulkin_grant_ff <= 1'b1;
                    bulkin_len_ff   <= rx_fifo_count[6:0];
                end
            end
        end
    end
    assign bulkin_grant = bulkin_grant_ff;
    assign bulkin_len   = bulkin_len_ff;

    // Remote wakeup on a falling ring-pin edge while suspended
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ring_prev_ff <= 1'b1;
            wake_ff      <= 1'b0;
        end else begin
            ring_prev_ff <= gpio_in[ufm_pkg::PIN_RING];
            wake_ff      <= suspended && wake_attr && !gpio_dir[ufm_pkg::PIN_RING]
                            && ring_prev_ff && !gpio_in[ufm_pkg::PIN_RING];
        end
    end
    assign remote_wake = wake_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_addr_byte;
        rx_valid && rx_bit9 && multidrop && !(half_duplex && tx_busy);
    endsequence

    sequence s_pause_seen;
        mode == ufm_pkg::MODE_SW && rx_take && rx_data == pause_char;
    endsequence

    a_rts_room: assert property (hw_rts |=> gpio_out[5] == !$past(rx_fifo_room))
        else $error("request line does not follow fifo room");
    a_cts_hold: assert property (hw_rts && gpio_in[4] |=> !tx_allow)
        else $error("transmit allowed while clear-to-send deasserted");
    a_pause_stop: assert property (s_pause_seen ##1 mode == ufm_pkg::MODE_SW |=> !tx_allow)
        else $error("transmit not stopped after pause char");
    a_addr_drop: assert property (s_addr_byte |=> !rx_store)
        else $error("address byte stored");
    a_addr_miss: assert property (s_addr_byte ##0 !addr_hit |=> !rx_enabled)
        else $error("receiver still enabled after foreign address");
    a_md4_tx: assert property (mode == 3'h4 && !match_ff |=> !tx_allow)
        else $error("mode 4 transmit without match");
    a_md3_tx: assert property (mode == 3'h3 |=> tx_allow)
        else $error("mode 3 transmit blocked");
    a_hd_rx: assert property (half_duplex && tx_busy |=> rx_line_out && !rx_store)
        else $error("receive activity seen while transmitting half duplex");
    a_full_pkt: assert property (bulkin_req && !low_latency_ff
                                && rx_fifo_count < CNTW'(ufm_pkg::PKT_MAX)
                                |=> !bulkin_grant)
        else $error("short packet granted outside low latency");
    a_wake_edge: assert property (remote_wake |-> $past(suspended) && $past(ring_prev_ff))
        else $error("wakeup without suspended falling edge");
    a_cfg_zero: assert property (flow_cfg_rd[7:4] == 4'h0)
        else $error("upper config bits not zero");
    a_cfg_write: assert property (flow_cfg_we |=> flow_cfg_rd[3:0] == $past(flow_cfg_wr[3:0]))
        else $error("config write not taken");
endmodule
`default_nettype wire

// File: ufm_pkg.sv
`default_nettype none
package ufm_pkg;

    // Handshake configuration byte, one per channel block
    localparam logic [7:0]  FLOW_CFG_ADDR   = 8'h0c;
    localparam int          HALF_DUPLEX_BIT = 3;
    localparam logic [7:0]  FLOW_CFG_RESET  = 8'h00;

    // Flow control mode field values
    localparam logic [2:0]  MODE_NONE = 3'h0;
    localparam logic [2:0]  MODE_HW   = 3'h1;
    localparam logic [2:0]  MODE_SW   = 3'h2;
    localparam logic [2:0]  MODE_MD3  = 3'h3;
    localparam logic [2:0]  MODE_MD4  = 3'h4;

    // Pin function select values
    localparam logic [2:0]  PINF_GPIO = 3'h0;
    localparam logic [2:0]  PINF_RTS  = 3'h1;
    localparam logic [2:0]  PINF_DTR  = 3'h2;
    localparam logic [2:0]  PINF_XCVR = 3'h3;

    // Pin positions
    localparam int          NUM_PINS  = 6;
    localparam int          PIN_RING  = 0;
    localparam int          PIN_DSR   = 2;
    localparam int          PIN_DTR   = 3;
    localparam int          PIN_CTS   = 4;
    localparam int          PIN_RTS   = 5;

    // Bulk-in packet size and low-latency baud threshold
    localparam logic [9:0]  PKT_MAX        = 10'h040;
    localparam logic [23:0] LOWLAT_BAUD    = 24'h00b749;

    // Turnaround delay limits in bit times
    localparam logic [3:0]  TAD_NONE = 4'h0;

    // Turnaround sequencer states
    typedef enum logic [1:0] {
        TAD_IDLE  = 2'b00,
        TAD_SEND  = 2'b01,
        TAD_COUNT = 2'b10
    } ufm_tad_type;

endpackage
`default_nettype wire

// File: ufm_turnaround.sv
`timescale 1ns/1ps
`default_nettype none
module ufm_turnaround #(
    parameter int BITW = 16
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    // Transmitter status
    input  wire logic            tx_busy,
    input  wire logic            tx_done,
    input  wire logic            tx_empty,
    // Configuration
    input  wire logic [3:0]      delay_bits,
    input  wire logic [BITW-1:0] bit_cycles,
    // Direction line hold, high while driven
    output logic                 hold
);
    ufm_pkg::ufm_tad_type state_ff;
    logic [BITW-1:0]      div_ff;
    logic [3:0]           bits_ff;
    logic                 bit_tick;

    // Bit-time enable pulse from the divider
    assign bit_tick = (state_ff == ufm_pkg::TAD_COUNT) && (div_ff == '0);

    // Sequencer: hold through the frame, then count whole bit times
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= ufm_pkg::TAD_IDLE;
            div_ff   <= '0;
            bits_ff  <= 4'h0;
        end else begin
            case (state_ff)
                ufm_pkg::TAD_IDLE: begin
                    if (tx_busy)
                        state_ff <= ufm_pkg::TAD_SEND;
                end
                ufm_pkg::TAD_SEND: begin
                    if (tx_done && tx_empty) begin
                        if (delay_bits == ufm_pkg::TAD_NONE) begin
                            state_ff <= ufm_pkg::TAD_IDLE;
                        end else begin
                            state_ff <= ufm_pkg::TAD_COUNT;
                            div_ff   <= bit_cycles - 1'b1;
                            bits_ff  <= delay_bits;
                        end
                    end
                end
                ufm_pkg::TAD_COUNT: begin
                    if (tx_busy) begin
                        state_ff <= ufm_pkg::TAD_SEND;
                    end else if (bit_tick) begin
                        div_ff  <= bit_cycles - 1'b1;
                        bits_ff <= bits_ff - 1'b1;
                        if (bits_ff == 4'h1)
                            state_ff <= ufm_pkg::TAD_IDLE;
                    end else begin
                        div_ff <= div_ff - 1'b1;
                    end
                end
                default: state_ff <= ufm_pkg::TAD_IDLE;
            endcase
        end
    end

    assign hold = (state_ff != ufm_pkg::TAD_IDLE) || tx_busy;
endmodule
`default_nettype wire

// File: ufm_remote.sv
`timescale 1ns/1ps
`default_nettype none
// Remote UART or multidrop master at the far end of the serial link
module ufm_remote (
    // Clock
    input  wire logic       ref_clk,
    // Modem and ring lines seen by the device
    output logic      [5:0] pins,
    // Received character stream and raw line
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_bit9,
    output logic            rx_line
);
    // Idle: modem lines deasserted high, serial line marking
    initial begin
        pins     = 6'h3f;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_bit9  = 1'b0;
        rx_line  = 1'b1;
    end

    // One character for one cycle; address bytes carry the ninth bit set
    task automatic send(input logic [7:0] d, input logic b9);
        rx_valid = 1'b1;
        rx_data  = d;
        rx_bit9  = b9;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_data  = ~d; // Stale bus must not look valid
        rx_bit9  = ~b9;
    endtask

    // Throttle and ring lines driven by the remote party
    task automatic set_pin(input int i, input logic v);
        pins[i] = v;
    endtask

    // Raw line activity
    task automatic set_line(input logic v);
        rx_line = v;
    endtask
endmodule
`default_nettype wire

// File: ufm_flow_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ufm_flow_ctrl_bench;
    // Clock, reset and host-side controls
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  flow_cfg_wr = 8'h00;
    logic        flow_cfg_we = 1'b0;
    logic [2:0]  pin_func = 3'h0;
    logic [3:0]  turnaround_delay_reg = 4'h0;
    logic [7:0]  resume_char = 8'h11;
    logic [7:0]  pause_char = 8'h13;
    logic [15:0] bit_cycles = 16'h0004;
    logic        low_latency_bit = 1'b0;
    logic        line_coding_stb = 1'b0;
    logic [23:0] line_coding_baud = 24'h000000;
    logic [5:0]  gpio_dout = 6'h00;
    logic [5:0]  gpio_dir = 6'h00;
    logic        tx_busy = 1'b0;
    logic        tx_done = 1'b0;
    logic        tx_empty = 1'b1;
    logic        rx_fifo_room = 1'b1;
    logic [9:0]  rx_fifo_count = 10'h000;
    logic        bulkin_req = 1'b0;
    logic        suspended = 1'b0;
    logic        wake_attr = 1'b0;
    // Device outputs and far-side lines
    logic [7:0]  flow_cfg_rd, rx_data, rx_store_data;
    logic [5:0]  gpio_in, gpio_out, gpio_oe;
    logic [6:0]  bulkin_len;
    logic        tx_allow, rx_line_in, rx_line_out, rx_valid, rx_bit9, rx_store;
    logic        rx_enabled, bulkin_grant, low_latency, remote_wake;
    int          err_count = 0;
    int          tests_run = 0;

    // Device and remote party
    ufm_flow_ctrl DUT (
        .ref_clk, .reset_n, .flow_cfg_wr, .flow_cfg_we, .flow_cfg_rd, .pin_func,
        .turnaround_delay_reg, .resume_char, .pause_char, .bit_cycles, .low_latency_bit,
        .line_coding_stb, .line_coding_baud, .gpio_in, .gpio_dout, .gpio_dir, .gpio_out,
        .gpio_oe, .tx_busy, .tx_done, .tx_empty, .tx_allow, .rx_line_in, .rx_line_out,
        .rx_valid, .rx_data, .rx_bit9, .rx_store, .rx_store_data, .rx_enabled,
        .rx_fifo_room, .rx_fifo_count, .bulkin_req, .bulkin_grant, .bulkin_len,
        .low_latency, .suspended, .wake_attr, .remote_wake
    );
    ufm_remote far (.ref_clk(ref_clk), .pins(gpio_in), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_bit9(rx_bit9), .rx_line(rx_line_in));

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    // Comparison and reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Configuration byte write, one-cycle strobe
    task automatic cfg(input logic [7:0] v);
        flow_cfg_wr = v;
        flow_cfg_we = 1'b1;
        tick(1);
        flow_cfg_we = 1'b0;
        tick(1);
    endtask

    // One received character and whether it reaches the fifo
    task automatic rx(input logic [7:0] d, input logic b9, input logic st);
        far.send(d, b9);
        check(rx_store, st);
        if (st) check(rx_store_data, d);
        tick(1);
    endtask

    // Host IN request and the grant it earns
    task automatic bulk(input logic g, input logic [6:0] len);
        bulkin_req = 1'b1;
        tick(1);
        bulkin_req = 1'b0;
        check(bulkin_grant, g);
        if (g) check(bulkin_len, len);
        tick(1);
    endtask

    // Line coding request and resulting latency mode
    task automatic coding(input logic [23:0] baud, input logic exp);
        line_coding_baud = baud;
        line_coding_stb  = 1'b1;
        tick(1);
        line_coding_stb  = 1'b0;
        tick(2);
        check(low_latency, exp);
    endtask

    // Falling edge on the ring pin, count wake pulses
    task automatic wake(input int exp);
        int n;
        n = 0;
        far.set_pin(0, 1'b1);
        tick(2);
        far.set_pin(0, 1'b0);
        repeat (4) begin
            tick(1);
            if (remote_wake === 1'b1) n++;
        end
        check(n, exp);
    endtask

    // Direction line release after the last stop bit, bit_cycles = 4
    task automatic turn(input int d);
        int n;
        turnaround_delay_reg = d[3:0];
        tx_busy  = 1'b1;
        tx_empty = 1'b0;
        tick(3);
        check(gpio_out[5], 1'b0);
        check(gpio_oe[5], 1'b1);
        tx_busy  = 1'b0;
        tx_done  = 1'b1;
        tx_empty = 1'b1;
        tick(1);
        tx_done = 1'b0;
        n = 1;
        while (gpio_out[5] !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n, d * 4 + 2);
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #20000;
        err_count++;
        results();
    end

    // Main sequence
    initial begin
        tick(12);
        check(flow_cfg_rd, 8'h00);
        check(gpio_oe, 6'h00);
        check({tx_allow, rx_line_out, low_latency}, 3'b110);
        reset_n = 1'b1;
        tick(1);
        cfg(8'hff);
        check(flow_cfg_rd, 8'h0f);
        cfg(8'h00);
        // Plain pins and no throttling in mode zero
        gpio_dir  = 6'h3b;
        gpio_dout = 6'h19;
        rx_fifo_room = 1'b0;
        far.set_pin(4, 1'b1);
        tick(2);
        check(gpio_oe, 6'h3b);
        check(gpio_out & gpio_oe, 6'h19);
        check(tx_allow, 1'b1);
        rx(pause_char, 1'b0, 1'b1);
        tick(3);
        check(tx_allow, 1'b1);
        // Request and clear lines on pins 5 and 4
        pin_func = ufm_pkg::PINF_RTS;
        cfg({5'h00, ufm_pkg::MODE_HW});
        tick(2);
        check(gpio_out[5], 1'b1);
        check({gpio_oe[5], gpio_oe[4]}, 2'b10);
        check(tx_allow, 1'b0);
        rx_fifo_room = 1'b1;
        far.set_pin(4, 1'b0);
        tick(2);
        check(gpio_out[5], 1'b0);
        check(tx_allow, 1'b1);
        // Same throttling on pins 3 and 2
        pin_func = ufm_pkg::PINF_DTR;
        rx_fifo_room = 1'b0;
        far.set_pin(2, 1'b1);
        tick(2);
        check(gpio_out[3], 1'b1);
        check(tx_allow, 1'b0);
        rx_fifo_room = 1'b1;
        far.set_pin(2, 1'b0);
        tick(2);
        check(gpio_out[3], 1'b0);
        check(tx_allow, 1'b1);
        // In-band pause and resume
        pin_func = ufm_pkg::PINF_GPIO;
        cfg({5'h00, ufm_pkg::MODE_SW});
        rx(pause_char, 1'b0, 1'b1);
        tick(2);
        check(tx_allow, 1'b0);
        rx(8'h41, 1'b0, 1'b1);
        check(tx_allow, 1'b0);
        rx(resume_char, 1'b0, 1'b1);
        tick(2);
        check(tx_allow, 1'b1);
        // Multidrop with transmitter always on
        cfg({5'h00, ufm_pkg::MODE_MD3});
        rx(resume_char, 1'b1, 1'b0);
        check(rx_enabled, 1'b1);
        rx(8'h5a, 1'b0, 1'b1);
        rx(8'h77, 1'b1, 1'b0);
        check(rx_enabled, 1'b0);
        rx(8'h5b, 1'b0, 1'b0);
        check(tx_allow, 1'b1);
        // Multidrop with transmitter gated by the match
        cfg({5'h00, ufm_pkg::MODE_MD4});
        rx(pause_char, 1'b1, 1'b0);
        rx(8'h5c, 1'b0, 1'b1);
        tick(1);
        check(tx_allow, 1'b1);
        rx(8'h78, 1'b1, 1'b0);
        tick(1);
        check(tx_allow, 1'b0);
        // Half duplex ignores the line while sending
        cfg(8'h08);
        tx_busy = 1'b1;
        far.set_line(1'b0);
        tick(2);
        check(rx_line_out, 1'b1);
        rx(8'h42, 1'b0, 1'b0);
        tx_busy = 1'b0;
        tick(2);
        check(rx_line_out, 1'b0);
        rx(8'h43, 1'b0, 1'b1);
        far.set_line(1'b1);
        // Bulk-in sizing and latency modes
        cfg(8'h00);
        rx_fifo_count = 10'h03f;
        bulk(1'b0, 7'h00);
        rx_fifo_count = 10'h040;
        bulk(1'b1, 7'h40);
        rx_fifo_count = 10'h00a;
        bulk(1'b0, 7'h00);
        low_latency_bit = 1'b1;
        tick(2);
        check(low_latency, 1'b1);
        bulk(1'b1, 7'h0a);
        low_latency_bit = 1'b0;
        coding(24'h00b748, 1'b1);
        bulk(1'b1, 7'h0a);
        rx_fifo_count = 10'h000;
        bulk(1'b0, 7'h00);
        coding(ufm_pkg::LOWLAT_BAUD, 1'b0);
        // Remote wakeup conditions
        gpio_dir  = 6'h3a;
        suspended = 1'b1;
        wake_attr = 1'b1;
        wake(1);
        wake_attr = 1'b0;
        wake(0);
        wake_attr = 1'b1;
        gpio_dir  = 6'h3b;
        wake(0);
        gpio_dir  = 6'h3a;
        suspended = 1'b0;
        wake(0);
        // Transceiver direction release delays
        pin_func = ufm_pkg::PINF_XCVR;
        turn(0);
        turn(1);
        turn(15);
        results();
    end
endmodule
`default_nettype wire
